// *** rtl/adc_ctrl_pkg.sv ***
// register map, field positions, reset values and timing counts of the converter control bank
// assumes one core clock; the serial control pins are sampled as synchronous inputs
// Function
// - source field 7:6; 00 gives normal data
// - source 01 sends fixed built-in pattern
// - source 10 sends user pattern registers
// - lane bit clear: both lanes, half word period
// - lane bit set: lane one only, lane zero floats
// - bit 4 turns duty cycle fixer on
// - bit 3 set gives two's complement coding
// - dual lane, alignment clear: half word stagger
// - dual lane, alignment set: lane one one cycle late
// - bit 1 puts channel A to sleep
// - bit 0 puts channel B to sleep
// - first pattern register bits 5:0 are upper six
// - second pattern register bits 7:2 are lower six
// - fixed pattern is 101001100011, msb first
// - registers govern only while serial enable high
// - each register access is sixteen clocked bits
package adc_ctrl_pkg;
   // register addresses
   localparam logic [1:0] ADDR_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_PAT_UPPER = 2'h1;
   localparam logic [1:0] ADDR_PAT_LOWER = 2'h2;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h08;
   localparam logic [7:0] PAT_UPPER_RESET = 8'h00;
   localparam logic [7:0] PAT_LOWER_RESET = 8'h00;
   // control register fields
   localparam int SRC_HI = 7;
   localparam int SRC_LO = 6;
   localparam int LANE_BIT = 5;
   localparam int FIXER_BIT = 4;
   localparam int CODING_BIT = 3;
   localparam int ALIGN_BIT = 2;
   localparam int SLEEP_A_BIT = 1;
   localparam int SLEEP_B_BIT = 0;
   // pattern register fields
   localparam int PAT_UPPER_MSB = 5;
   localparam int PAT_LOWER_MSB = 7;
   localparam int PAT_LOWER_LSB = 2;
   // output source codes
   localparam logic [1:0] SRC_NORMAL = 2'h0;
   localparam logic [1:0] SRC_FIXED = 2'h1;
   localparam logic [1:0] SRC_USER = 2'h2;
   localparam logic [1:0] SRC_RESERVED = 2'h3;
   localparam logic [11:0] FIXED_PATTERN = 12'ha63;
   // serial frame layout
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] FIRST_BYTE_BITS = 5'h08;
   localparam int RW_BIT = 15;
   localparam int ADDR_HI = 9;
   localparam int ADDR_LO = 8;
   // word timing in core clock cycles
   localparam logic [3:0] SINGLE_PERIOD = 4'hc;
   localparam logic [3:0] DUAL_PERIOD = 4'h6;
   localparam int STAGGER_DELAY = 3;
   localparam int ALIGN_DELAY = 1;
endpackage : adc_ctrl_pkg

// *** rtl/adc_ctrl_regs.sv ***
// control register bank of the dual converter: serial control port, source select, word framing
// assumes serial pins are synchronous to core_clk and sclk is much slower than core_clk
`timescale 1ns/1ps
module adc_ctrl_regs import adc_ctrl_pkg::*; #(
   parameter int WORD_W = 12
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic spi_en,
   input wire logic pin_test,
   input wire logic pin_lane_count,
   input wire logic pin_fixer_coding,
   input wire logic pin_align,
   input wire logic pin_sleep_a,
   input wire logic pin_sleep_b,
   input wire logic ctl_clk,
   input wire logic ctl_sel_n,
   input wire logic ctl_din,
   output logic ctl_dout,
   output logic ctl_dout_oe,
   input wire logic [WORD_W-1:0] sample_a,
   input wire logic [WORD_W-1:0] sample_b,
   output logic lane_zero_out_a,
   output logic lane_zero_oe_a,
   output logic lane_one_out_a,
   output logic lane_zero_out_b,
   output logic lane_zero_oe_b,
   output logic lane_one_out_b,
   output logic word_start,
   output logic duty_cycle_fixer_on,
   output logic chan_a_sleep,
   output logic chan_b_sleep
);
   typedef struct packed {
      logic [7:0] control;
      logic [7:0] pat_upper;
      logic [7:0] pat_lower;
      logic sclk_q;
      logic sel_q;
      logic [4:0] bit_cnt;
      logic [15:0] shreg;
      logic [7:0] rd_shift;
      logic dout;
      logic dout_oe;
      logic [3:0] word_cnt;
      logic load;
      logic [WORD_W-1:0] word_a;
      logic [WORD_W-1:0] word_b;
      logic fixer;
      logic sleep_a;
      logic sleep_b;
      logic dual;
      logic align;
   } ctrl_state_t;

   ctrl_state_t s;
   ctrl_state_t next_s;
   logic [1:0] eff_src;
   logic eff_coding;
   logic [3:0] period;
   logic [WORD_W-1:0] user_word;

   // register read mux; address 3 reads as zero
   function automatic logic [7:0] reg_read(input ctrl_state_t st, input logic [1:0] addr);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         ADDR_CONTROL: v = st.control;
         ADDR_PAT_UPPER: v = st.pat_upper;
         ADDR_PAT_LOWER: v = st.pat_lower;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : reg_read

   // samples arrive offset binary; two's complement flips the msb
   function automatic logic [WORD_W-1:0] coded(input logic [WORD_W-1:0] x, input logic tc);
      return tc ? {~x[WORD_W-1], x[WORD_W-2:0]} : x;
   endfunction : coded

   // effective configuration: registers while serial enable is high, pins otherwise
   always_comb begin
      if (spi_en) begin
         case (s.control[SRC_HI:SRC_LO])
            SRC_FIXED: eff_src = SRC_FIXED;
            SRC_USER: eff_src = SRC_USER;
            default: eff_src = SRC_NORMAL;
         endcase
         eff_coding = s.control[CODING_BIT];
      end else begin
         eff_src = pin_test ? SRC_FIXED : SRC_NORMAL;
         eff_coding = pin_fixer_coding;
      end
   end

   assign period = s.dual ? DUAL_PERIOD : SINGLE_PERIOD;
   assign user_word = {s.pat_upper[PAT_UPPER_MSB:0],
                       s.pat_lower[PAT_LOWER_MSB:PAT_LOWER_LSB]};

   // serial control port and word framing
   always_comb begin
      logic rise;
      logic fall;
      logic [7:0] rd;
      rise = ctl_clk & ~s.sclk_q;
      fall = ~ctl_clk & s.sclk_q;
      rd = reg_read(s, s.shreg[ADDR_HI-8:ADDR_LO-8]);
      next_s = s;
      next_s.sclk_q = ctl_clk;
      next_s.sel_q = ctl_sel_n;
      if (!ctl_sel_n) begin
         next_s.dout_oe = 1'b1;
         if (s.sel_q) begin
            // fresh select starts a new frame
            next_s.bit_cnt = 5'h00;
         end else if (rise && s.bit_cnt != FRAME_BITS) begin
            next_s.shreg = {s.shreg[14:0], ctl_din};
            next_s.bit_cnt = s.bit_cnt + 5'h01;
         end
         // read data leaves on the falling edges of the second byte
         if (fall && s.bit_cnt == FIRST_BYTE_BITS) begin
            next_s.dout = rd[7];
            next_s.rd_shift = {rd[6:0], 1'b0};
         end else if (fall && s.bit_cnt > FIRST_BYTE_BITS && s.bit_cnt < FRAME_BITS) begin
            next_s.dout = s.rd_shift[7];
            next_s.rd_shift = {s.rd_shift[6:0], 1'b0};
         end
      end else begin
         next_s.dout_oe = 1'b0;
         next_s.dout = 1'b0;
         next_s.bit_cnt = 5'h00;
         // commit on deselect only after a full frame; short frames are dropped
         if (!s.sel_q && s.bit_cnt == FRAME_BITS && !s.shreg[RW_BIT]) begin
            case (s.shreg[ADDR_HI:ADDR_LO])
               ADDR_CONTROL: next_s.control = s.shreg[7:0];
               ADDR_PAT_UPPER: next_s.pat_upper = s.shreg[7:0];
               ADDR_PAT_LOWER: next_s.pat_lower = s.shreg[7:0];
               default: next_s.control = s.control;
            endcase
         end
      end
      // static configuration outputs
      next_s.fixer = spi_en ? s.control[FIXER_BIT] : pin_fixer_coding;
      next_s.sleep_a = spi_en ? s.control[SLEEP_A_BIT] : pin_sleep_a;
      next_s.sleep_b = spi_en ? s.control[SLEEP_B_BIT] : pin_sleep_b;
      next_s.dual = spi_en ? ~s.control[LANE_BIT] : ~pin_lane_count;
      // alignment is meaningless in single lane; the host keeps it clear there
      next_s.align = spi_en ? s.control[ALIGN_BIT] : pin_align;
      // word boundary: period follows lane count, and a period change restarts cleanly
      next_s.load = 1'b0;
      if (s.word_cnt >= period - 4'h1) begin
         next_s.word_cnt = 4'h0;
         next_s.load = 1'b1;
         case (eff_src)
            SRC_FIXED: begin
               next_s.word_a = FIXED_PATTERN;
               next_s.word_b = FIXED_PATTERN;
            end
            SRC_USER: begin
               next_s.word_a = user_word;
               next_s.word_b = user_word;
            end
            default: begin
               // a sleeping channel sends zeros instead of stale pipeline data
               next_s.word_a = s.sleep_a ? '0 : coded(sample_a, eff_coding);
               next_s.word_b = s.sleep_b ? '0 : coded(sample_b, eff_coding);
            end
         endcase
      end else begin
         next_s.word_cnt = s.word_cnt + 4'h1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.control <= CONTROL_RESET;
         s.pat_upper <= PAT_UPPER_RESET;
         s.pat_lower <= PAT_LOWER_RESET;
         s.sel_q <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // one serializer per channel
   logic [WORD_W-1:0] ch_word [2];
   logic [1:0] ch_l0;
   logic [1:0] ch_oe;
   logic [1:0] ch_l1;
   assign ch_word[0] = s.word_a;
   assign ch_word[1] = s.word_b;

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      lane_serializer #(.WORD_W(WORD_W)) u_ser (
         .core_clk(core_clk),
         .rst(rst),
         .load(s.load),
         .word(ch_word[ch]),
         .dual(s.dual),
         .align(s.align),
         .lane0_bit(ch_l0[ch]),
         .lane0_oe(ch_oe[ch]),
         .lane1_bit(ch_l1[ch])
      );
   end

   // outputs straight from flops
   assign ctl_dout = s.dout;
   assign ctl_dout_oe = s.dout_oe;
   assign lane_zero_out_a = ch_l0[0];
   assign lane_zero_oe_a = ch_oe[0];
   assign lane_one_out_a = ch_l1[0];
   assign lane_zero_out_b = ch_l0[1];
   assign lane_zero_oe_b = ch_oe[1];
   assign lane_one_out_b = ch_l1[1];
   assign word_start = s.load;
   assign duty_cycle_fixer_on = s.fixer;
   assign chan_a_sleep = s.sleep_a;
   assign chan_b_sleep = s.sleep_b;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // source checks look one cycle past the word boundary, where the new words stand
   a_normal_source: assert property (
      spi_en && s.control[7:6] == SRC_NORMAL && !s.sleep_a && !s.load
      && s.word_cnt >= period - 4'h1
      |=> s.word_a == coded($past(sample_a), $past(eff_coding)))
      else $error("normal word not taken from conversion");
   a_fixed_source: assert property (
      spi_en && s.control[7:6] == SRC_FIXED && s.word_cnt >= period - 4'h1
      |=> s.word_a == 12'ha63 && s.word_b == 12'ha63)
      else $error("fixed pattern not sent");
   a_user_source: assert property (
      spi_en && s.control[7:6] == SRC_USER && s.word_cnt >= period - 4'h1
      |=> s.word_b == {$past(s.pat_upper[5:0]), $past(s.pat_lower[7:2])})
      else $error("user pattern not assembled");

   // lane zero enable trails the lane bit by two flops, one more right after reset
   a_dual_lanes: assert property (
      (spi_en && !s.control[5])[*4] |-> lane_zero_oe_a && lane_zero_oe_b)
      else $error("lane zero not driven in dual lane");
   a_single_lane: assert property (
      (spi_en && s.control[5])[*3] |-> !lane_zero_oe_a && !lane_zero_oe_b)
      else $error("lane zero driven in single lane");
   a_direct_single: assert property (
      (!spi_en && pin_lane_count)[*3] |-> !lane_zero_oe_a && !lane_zero_oe_b)
      else $error("direct lane pin not followed");

   // static configuration follows the registers one flop later
   a_fixer_bit: assert property (
      spi_en |=> duty_cycle_fixer_on == $past(s.control[4]))
      else $error("duty cycle fixer does not follow bit 4");
   a_coding_msb: assert property (
      spi_en && s.control[3] && s.control[7:6] == SRC_NORMAL && !s.sleep_a
      && s.word_cnt >= period - 4'h1
      |=> s.word_a[11] == !$past(sample_a[11]))
      else $error("two's complement msb wrong");
   a_direct_coding: assert property (
      !spi_en && pin_fixer_coding && !pin_test && !s.sleep_b
      && s.word_cnt >= period - 4'h1
      |=> s.word_b[11] == !$past(sample_b[11]))
      else $error("direct coding pin not followed");
   a_sleep_a: assert property (
      spi_en ##1 spi_en |-> chan_a_sleep == $past(s.control[1]))
      else $error("channel A sleep wrong");
   a_sleep_b: assert property (
      spi_en ##1 spi_en |-> chan_b_sleep == $past(s.control[0]))
      else $error("channel B sleep wrong");
   // a sleeping channel must not leak stale conversion data into its lanes
   a_sleep_zero_a: assert property (
      s.sleep_a && eff_src == SRC_NORMAL && s.word_cnt >= period - 4'h1
      |=> s.word_a == '0)
      else $error("sleeping channel A still sends data");
   a_sleep_zero_b: assert property (
      s.sleep_b && eff_src == SRC_NORMAL && s.word_cnt >= period - 4'h1
      |=> s.word_b == '0)
      else $error("sleeping channel B still sends data");
   a_direct_pins: assert property (
      !spi_en |=> chan_a_sleep == $past(pin_sleep_a))
      else $error("direct pin not followed while serial disabled");
   a_direct_fixed: assert property (
      !spi_en && pin_test && s.word_cnt >= period - 4'h1 |=> s.word_a == 12'ha63)
      else $error("direct test pin not followed");
   a_reserved_mode: assert property (
      spi_en && s.control[7:6] == SRC_RESERVED && !s.sleep_b
      && s.word_cnt >= period - 4'h1
      |=> s.word_b == coded($past(sample_b), $past(eff_coding)))
      else $error("reserved source not normal");

   // serial port: only a whole write frame to a real address may touch a register
   a_full_frame: assert property (
      !$stable(s.control) |->
      $past(ctl_sel_n && !s.sel_q && s.bit_cnt == 5'h10 && !s.shreg[15]))
      else $error("register written without a full frame");
   a_frame_dropped: assert property (
      ctl_sel_n && !s.sel_q && (s.bit_cnt != 5'h10 || s.shreg[15] || s.shreg[9:8] == 2'h3)
      |=> $stable(s.control) && $stable(s.pat_upper) && $stable(s.pat_lower))
      else $error("short, read or unused frame changed a register");
   a_bit_count: assert property (
      s.bit_cnt <= FRAME_BITS)
      else $error("frame bit counter ran past sixteen");
   a_select_drive: assert property (
      !ctl_sel_n |=> ctl_dout_oe)
      else $error("read data not driven while selected");
   a_deselect_quiet: assert property (
      ctl_sel_n |=> !ctl_dout_oe && !ctl_dout)
      else $error("read data driven while deselected");

   // main scenarios: write and read frames, fixed pattern, single lane
   c_write_frame: cover property (ctl_sel_n && !s.sel_q && s.bit_cnt == 5'h10 && !s.shreg[15]);
   c_read_frame: cover property (!ctl_sel_n && s.bit_cnt == 5'h10 && s.shreg[15]);
   c_fixed_load: cover property (s.load && eff_src == SRC_FIXED);
   c_single_lane: cover property (s.load && !s.dual);
endmodule : adc_ctrl_regs

// *** rtl/lane_serializer.sv ***
// one channel's word serializer onto two lanes
// assumes a one-cycle load pulse at each word boundary from the control bank
`timescale 1ns/1ps
module lane_serializer import adc_ctrl_pkg::*; #(
   parameter int WORD_W = 12
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [WORD_W-1:0] word,
   input wire logic dual,
   input wire logic align,
   output logic lane0_bit,
   output logic lane0_oe,
   output logic lane1_bit
);
   localparam int HALF = WORD_W / 2;

   typedef struct packed {
      logic [WORD_W-1:0] sh1;
      logic [HALF-1:0] sh0;
      logic [STAGGER_DELAY-1:0] dly;
      logic out0;
      logic oe0;
      logic out1;
   } ser_state_t;

   ser_state_t s;
   ser_state_t next_s;

   // split, shift and delay; lane one gets the odd bits in dual mode
   always_comb begin
      logic [HALF-1:0] odd;
      logic [HALF-1:0] even;
      logic raw;
      odd = '0;
      even = '0;
      raw = s.sh1[WORD_W-1];
      next_s = s;
      for (int i = 0; i < HALF; i++) begin
         odd[i] = word[2*i+1];
         even[i] = word[2*i];
      end
      next_s.dly = {s.dly[STAGGER_DELAY-2:0], raw};
      if (load) begin
         if (dual) begin
            next_s.sh1 = {odd, {HALF{1'b0}}};
            next_s.sh0 = even;
         end else begin
            next_s.sh1 = word;
            next_s.sh0 = '0;
         end
      end else begin
         next_s.sh1 = {s.sh1[WORD_W-2:0], 1'b0};
         next_s.sh0 = {s.sh0[HALF-2:0], 1'b0};
      end
      // lane zero is released in single lane mode
      next_s.oe0 = dual;
      next_s.out0 = dual & s.sh0[HALF-1];
      // stagger by half a word, or align with one extra cycle on lane one
      if (!dual) begin
         next_s.out1 = raw;
      end else if (align) begin
         next_s.out1 = s.dly[ALIGN_DELAY-1];
      end else begin
         next_s.out1 = s.dly[STAGGER_DELAY-1];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign lane0_bit = s.out0;
   assign lane0_oe = s.oe0;
   assign lane1_bit = s.out1;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_lane_stagger: assert property (
      (dual && !align)[*5] |-> lane1_bit == $past(s.sh1[WORD_W-1], 4))
      else $error("lane one not staggered by half a word");
   a_lane_aligned: assert property (
      (dual && align)[*3] |-> lane1_bit == $past(s.sh1[WORD_W-1], 2))
      else $error("lane one not delayed by one cycle");
   c_aligned_load: cover property (dual && align && load);
endmodule : lane_serializer

// *** tb/ctl_host.sv ***
// host model of the serial control link: select, clocked frames msb first, read back
// assumes the device samples ctl_clk with core_clk, so each phase lasts three core cycles
`timescale 1ns/1ps
module ctl_host (
   input wire logic core_clk,
   output logic ctl_clk,
   output logic ctl_sel_n,
   output logic ctl_din,
   input wire logic ctl_dout,
   output logic rd_valid,
   output logic [7:0] rd_data
);
   // serial clock idles low and stands still between frames
   initial begin
      ctl_clk = 1'b0;
      ctl_sel_n = 1'b1;
      ctl_din = 1'b0;
      rd_valid = 1'b0;
      rd_data = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   // fewer than sixteen bits makes a short frame that the device must drop
   task automatic frame(input logic [15:0] f, input int nbits);
      logic [7:0] rd;
      rd = 8'h00;
      tick(1);
      ctl_sel_n <= 1'b0;
      tick(3);
      for (int k = 1; k <= nbits; k++) begin
         ctl_din <= f[16-k];
         tick(2);
         // read bits are taken before the rise, well after the falling edge moved them
         if (k >= 9) rd = {rd[6:0], ctl_dout};
         tick(1);
         ctl_clk <= 1'b1;
         tick(3);
         ctl_clk <= 1'b0;
      end
      tick(3);
      ctl_sel_n <= 1'b1;
      ctl_din <= ~ctl_din; // released line must not keep a stale level
      tick(4);
      if (f[15] && nbits == 16) begin
         rd_data <= rd;
         rd_valid <= 1'b1;
         tick(1);
         rd_valid <= 1'b0;
      end
   endtask : frame
endmodule : ctl_host

// *** tb/dual_adc_control_registers_bench.sv ***
// self-checking bench of the converter control bank: serial register access and lane output
// assumes the host model in ctl_host; words are captured after each armed word_start pulse
`timescale 1ns/1ps
module dual_adc_control_registers_bench import adc_ctrl_pkg::*;;
   typedef struct {logic [1:0] mode; logic [11:0] a; logic [11:0] b;} lane_note_t;
   logic core_clk, rst, spi_en, pin_test, pin_lane_count, pin_fixer_coding, pin_align;
   logic pin_sleep_a, pin_sleep_b, ctl_clk, ctl_sel_n, ctl_din, ctl_dout, ctl_dout_oe;
   logic [11:0] sample_a, sample_b, ra, rb, wa, wb;
   logic lane_zero_out_a, lane_zero_oe_a, lane_one_out_a, lane_zero_out_b, lane_zero_oe_b;
   logic lane_one_out_b, word_start, duty_cycle_fixer_on, chan_a_sleep, chan_b_sleep;
   logic rd_valid, arm, oe_a, oe_b;
   logic [7:0] rd_data;
   logic [5:0] up, lo;
   logic [14:0] l1a, l0a, l1b, l0b;
   int n_fail, num_checks, seed_v;
   logic [7:0] rd_q[$];
   lane_note_t ln_q[$];
   lane_note_t nt;
   adc_ctrl_regs uut (.core_clk(core_clk), .rst(rst), .spi_en(spi_en), .pin_test(pin_test),
      .pin_lane_count(pin_lane_count), .pin_fixer_coding(pin_fixer_coding),
      .pin_align(pin_align), .pin_sleep_a(pin_sleep_a), .pin_sleep_b(pin_sleep_b),
      .ctl_clk(ctl_clk), .ctl_sel_n(ctl_sel_n), .ctl_din(ctl_din), .ctl_dout(ctl_dout),
      .ctl_dout_oe(ctl_dout_oe), .sample_a(sample_a), .sample_b(sample_b),
      .lane_zero_out_a(lane_zero_out_a), .lane_zero_oe_a(lane_zero_oe_a),
      .lane_one_out_a(lane_one_out_a), .lane_zero_out_b(lane_zero_out_b),
      .lane_zero_oe_b(lane_zero_oe_b), .lane_one_out_b(lane_one_out_b),
      .word_start(word_start), .duty_cycle_fixer_on(duty_cycle_fixer_on),
      .chan_a_sleep(chan_a_sleep), .chan_b_sleep(chan_b_sleep));
   ctl_host host (.core_clk(core_clk), .ctl_clk(ctl_clk), .ctl_sel_n(ctl_sel_n),
      .ctl_din(ctl_din), .ctl_dout(ctl_dout), .rd_valid(rd_valid), .rd_data(rd_data));
   always #12.5 core_clk = ~core_clk;
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      // a note that never met its result is a mismatch too
      if (rd_q.size() != 0 || ln_q.size() != 0) begin
         n_fail++;
         $display("BAD %0t expected results left unchecked", $time);
      end
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   // bits 14:10 stay zero in every frame the host sends
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      host.frame({6'h00, a, d}, 16);
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      rd_q.push_back(exp);
      host.frame({1'b1, 5'h00, a, 8'h00}, 16);
   endtask : rd
   // mode 0 single lane, 1 dual aligned, 2 dual staggered
   task automatic lanes(input logic [1:0] m, input logic [11:0] a, input logic [11:0] b);
      ln_q.push_back('{m, a, b});
      repeat (30) @(posedge core_clk);
      arm = 1'b1;
      for (int i = 0; i < 100 && arm; i++) @(posedge core_clk);
      if (arm) begin
         n_fail++;
         $display("BAD %0t no word seen", $time);
         tally_and_finish();
      end
   endtask : lanes
   function automatic logic [11:0] pack(input logic [1:0] m, input logic [14:0] l1,
      input logic [14:0] l0);
      logic [11:0] w;
      int d;
      w = 12'h000;
      d = (m == 2'h0) ? 2 : ((m == 2'h1) ? 3 : 5);
      for (int j = 0; j < 12; j++) begin
         if (m == 2'h0) w[11-j] = l1[2+j];
         else if (j < 6) begin
            w[11-2*j] = l1[d+j];
            w[10-2*j] = l0[2+j];
         end
      end
      return w;
   endfunction : pack
   // read results are matched against the oldest note
   always @(negedge core_clk) begin
      if (rd_valid === 1'b1) begin
         if (rd_q.size() == 0) chk(12'h000, 12'hfff, "unexpected read");
         else chk({4'h0, rd_data}, {4'h0, rd_q.pop_front()}, "read data");
      end
   end
   // lane capture: sampled at the falling edge so bits are settled
   always @(negedge core_clk) begin
      if (arm && word_start === 1'b1 && ln_q.size() > 0) begin
         nt = ln_q.pop_front();
         for (int k = 1; k <= 14; k++) begin
            @(negedge core_clk);
            l1a[k] = lane_one_out_a;
            l0a[k] = lane_zero_out_a;
            l1b[k] = lane_one_out_b;
            l0b[k] = lane_zero_out_b;
            if (k == 2) oe_a = lane_zero_oe_a;
            if (k == 2) oe_b = lane_zero_oe_b;
         end
         wa = pack(nt.mode, l1a, l0a);
         wb = pack(nt.mode, l1b, l0b);
         chk(wa, nt.a, "word a");
         chk(wb, nt.b, "word b");
         chk({10'h0, oe_a, oe_b}, {10'h0, {2{nt.mode != 2'h0}}}, "lane zero enable");
         arm = 1'b0;
      end
   end
   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      arm = 1'b0;
      {spi_en, pin_test, pin_lane_count, pin_fixer_coding} = 4'h8;
      {pin_align, pin_sleep_a, pin_sleep_b} = 3'h0;
      n_fail = 0;
      num_checks = 0;
      seed_v = $urandom(92334);
      ra = 12'($urandom);
      rb = 12'($urandom);
      up = 6'($urandom);
      lo = 6'($urandom);
      sample_a = ra;
      sample_b = rb;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk({11'h0, ctl_dout_oe}, 12'h000, "idle data enable");
      rd(ADDR_CONTROL, 8'h08);
      rd(ADDR_PAT_UPPER, 8'h00);
      rd(ADDR_PAT_LOWER, 8'h00);
      lanes(2'h2, ra ^ 12'h800, rb ^ 12'h800);
      wr(ADDR_CONTROL, 8'h04);
      lanes(2'h1, ra, rb);
      wr(ADDR_CONTROL, 8'h60);
      lanes(2'h0, 12'ha63, 12'ha63);
      wr(ADDR_PAT_UPPER, {2'h0, up});
      wr(ADDR_PAT_LOWER, {lo, 2'h0});
      wr(ADDR_CONTROL, 8'ha0);
      lanes(2'h0, {up, lo}, {up, lo});
      rd(ADDR_PAT_UPPER, {2'h0, up});
      host.frame({8'h00, 8'h10}, 15);
      rd(ADDR_CONTROL, 8'ha0);
      wr(ADDR_CONTROL, 8'he8);
      lanes(2'h0, ra ^ 12'h800, rb ^ 12'h800);
      wr(ADDR_CONTROL, 8'h12);
      chk({10'h0, duty_cycle_fixer_on, chan_a_sleep}, 12'h003, "fixer, sleep a");
      lanes(2'h2, 12'h000, rb);
      wr(ADDR_CONTROL, 8'h01);
      chk({10'h0, duty_cycle_fixer_on, chan_b_sleep}, 12'h001, "fixer, sleep b");
      lanes(2'h2, ra, 12'h000);
      wr(2'h3, 8'hff);
      rd(2'h3, 8'h00);
      rd(ADDR_CONTROL, 8'h01);
      spi_en <= 1'b0;
      {pin_test, pin_lane_count, pin_sleep_a} <= 3'h7;
      repeat (4) @(posedge core_clk);
      chk({11'h0, chan_a_sleep}, 12'h001, "direct sleep a");
      lanes(2'h0, 12'ha63, 12'ha63);
      // direct pins: dual aligned lanes, two's complement, channel A asleep
      {pin_test, pin_lane_count, pin_fixer_coding, pin_align} <= 4'h3;
      repeat (4) @(posedge core_clk);
      chk({11'h0, duty_cycle_fixer_on}, 12'h001, "direct fixer");
      lanes(2'h1, 12'h000, rb ^ 12'h800);
      spi_en <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk({10'h0, chan_a_sleep, chan_b_sleep}, 12'h001, "pins ignored");
      chk({11'h0, duty_cycle_fixer_on}, 12'h000, "fixer pin ignored");
      lanes(2'h2, ra, 12'h000);
      tally_and_finish();
   end
endmodule : dual_adc_control_registers_bench
